/* logic/pbm_pkg.sv */
// Contract
// - reset bit starts port reset, reads one
// - reset completion reloads configuration from straps
// - loopback routes transmit data to receive path
// - loopback may blank receive data 500 us
// - speed bit picks speed, one means 100
// - autonegotiation on ignores speed and duplex bits
// - event bits follow their event, no software
// - cleared-by-read bits unwritable, read clears them
// - fixed bits read default, ignore writes
// - latched-low bit holds zero until read
// - latched-high bit holds one until read
package pbm_pkg;

  localparam logic [4:0]  REG_BASIC_CTRL  = 5'h00;
  localparam logic [4:0]  REG_LINK_STATUS = 5'h01;
  localparam logic [4:0]  REG_LQ_MON      = 5'h1D;
  localparam logic [4:0]  REG_LQ_DATA     = 5'h1E;

  localparam int          BC_RESET   = 15;
  localparam int          BC_LOOP    = 14;
  localparam int          BC_SPEED   = 13;
  localparam int          BC_ANEN    = 12;
  localparam int          BC_DUPLEX  = 8;
  localparam logic [15:0] BC_MASK    = 16'hF100;

  localparam int          LS_FIXED   = 0;
  localparam int          LS_EVENT   = 1;
  localparam int          LS_LINK    = 2;
  localparam int          LS_JABBER  = 3;
  localparam int          LS_ERR_LO  = 8;
  localparam logic        LS_FIXED_VAL = 1'b1;

  localparam int          LQM_ENABLE = 15;
  localparam int          LQM_WARNS  = 10;
  localparam logic [15:0] LQM_MASK   = 16'h83FF;

  localparam int          LQD_SAMPLE = 13;
  localparam int          LQD_WRTHR  = 12;
  localparam int          LQD_PSEL   = 9;
  localparam int          LQD_TSEL   = 8;
  localparam int          LQ_PARAMS  = 5;
  localparam logic [15:0] LQD_MASK   = 16'h3FFF;

  localparam int          CLK_MHZ         = 40;
  localparam int          SWRESET_NS      = 1000;
  localparam int          SWRESET_CYCLES  = (SWRESET_NS * CLK_MHZ + 999) / 1000;
  localparam int          DEADTIME_US     = 500;
  localparam int          DEADTIME_CYCLES = DEADTIME_US * CLK_MHZ;

  localparam logic [5:0]  PREAMBLE_LEN = 6'h20;
  localparam logic [5:0]  HDR_LAST     = 6'h0B;
  localparam logic [5:0]  DATA_LAST    = 6'h0F;
  localparam logic [1:0]  OP_READ      = 2'h2;
  localparam logic [1:0]  OP_WRITE     = 2'h1;

  typedef enum logic [2:0] {MS_PRE, MS_START, MS_HDR, MS_TA, MS_DATA} pbm_mdio_e;

endpackage : pbm_pkg

/* logic/pbm_mdio_slave.sv */
`timescale 1ns/1ps
module pbm_mdio_slave (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        mdc,
  input  wire logic        mdioIn,
  input  wire logic [4:0]  phyAddr,
  input  wire logic [15:0] rdData,
  output logic             mdioOut,
  output logic             mdioOe,
  output logic             regRe,
  output logic             regWe,
  output logic [4:0]       regAddr,
  output logic [15:0]      wrData
);
  import pbm_pkg::*;

  pbm_mdio_e   state;
  logic        mdcQ;
  logic        rise;
  logic [5:0]  cnt;
  logic [11:0] hdr;
  logic [11:0] nextHdr;
  logic        isRead;
  logic        isWrite;
  logic [15:0] shiftOut;

  // mdc is taken as synchronous; its rising edge is the bit strobe
  assign rise    = mdc & ~mdcQ;
  assign nextHdr = {hdr[10:0], mdioIn};

  always_ff @(posedge clk)
    mdcQ <= rst ? 1'b0 : mdc;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state   <= MS_PRE;
      cnt     <= 6'h00;
      hdr     <= 12'h000;
      isRead  <= 1'b0;
      isWrite <= 1'b0;
      regAddr <= 5'h00;
      wrData  <= 16'h0000;
      mdioOut <= 1'b0;
      mdioOe  <= 1'b0;
    end
    else if (rise)
    begin
      case (state)
        MS_PRE:
        begin
          if (mdioIn)
            cnt <= (cnt == PREAMBLE_LEN) ? cnt : cnt + 6'h01;
          else if (cnt == PREAMBLE_LEN)
          begin
            state <= MS_START;
            cnt   <= 6'h00;
          end
          else
            cnt <= 6'h00;
        end
        MS_START:
          state <= mdioIn ? MS_HDR : MS_PRE;
        MS_HDR:
        begin
          hdr <= nextHdr;
          if (cnt == HDR_LAST)
          begin
            state   <= MS_TA;
            cnt     <= 6'h00;
            regAddr <= nextHdr[4:0];
            isRead  <= (nextHdr[11:10] == OP_READ) && (nextHdr[9:5] == phyAddr);
            isWrite <= (nextHdr[11:10] == OP_WRITE) && (nextHdr[9:5] == phyAddr);
          end
          else
            cnt <= cnt + 6'h01;
        end
        MS_TA:
        begin
          if (cnt == 6'h00)
          begin
            cnt     <= 6'h01;
            mdioOe  <= isRead;
            mdioOut <= 1'b0;
          end
          else
          begin
            state   <= MS_DATA;
            cnt     <= 6'h00;
            mdioOut <= isRead & shiftOut[15];
          end
        end
        default:
        begin
          wrData <= {wrData[14:0], mdioIn};
          if (cnt == DATA_LAST)
          begin
            state  <= MS_PRE;
            cnt    <= 6'h00;
            mdioOe <= 1'b0;
          end
          else
          begin
            cnt     <= cnt + 6'h01;
            mdioOut <= isRead & shiftOut[14 - cnt[3:0]];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    regRe <= ~rst & rise & (state == MS_TA) & (cnt == 6'h00) & isRead;
    regWe <= ~rst & rise & (state == MS_DATA) & (cnt == DATA_LAST) & isWrite;
  end

  // read data is frozen the cycle the read side effects fire
  always_ff @(posedge clk)
    shiftOut <= rst ? 16'h0000 : (regRe ? rdData : shiftOut);

endmodule : pbm_mdio_slave

/* logic/pbm_loopback.sv */
`timescale 1ns/1ps
module pbm_loopback #(
  parameter int DEAD_CYCLES = 20000
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       loopEn,
  input  wire logic [3:0] txData,
  input  wire logic       txEn,
  input  wire logic [3:0] lineRxData,
  input  wire logic       lineRxDv,
  output logic [3:0]      rxData,
  output logic            rxDv
);
  import pbm_pkg::*;

  logic        loopQ;
  logic [15:0] deadCnt;
  logic        dead;

  assign dead = deadCnt != 16'h0000;

  // descrambler relock window after loopback turns on
  always_ff @(posedge clk)
  begin
    loopQ <= rst ? 1'b0 : loopEn;
    if (rst || !loopEn)
      deadCnt <= 16'h0000;
    else if (!loopQ)
      deadCnt <= 16'(DEAD_CYCLES);
    else if (dead)
      deadCnt <= deadCnt - 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    // first looped cycle is blanked too, before the window counter loads
    if (rst || (loopEn && (dead || !loopQ)))
    begin
      rxData <= 4'h0;
      rxDv   <= 1'b0;
    end
    else if (loopEn)
    begin
      rxData <= txData;
      rxDv   <= txEn;
    end
    else
    begin
      rxData <= lineRxData;
      rxDv   <= lineRxDv;
    end
  end

  AST_LOOP_ROUTE: assert property (@(posedge clk) disable iff (rst)
    (loopEn && loopQ && !dead) |=> (rxData == $past(txData)) && (rxDv == $past(txEn)))
    else $error("loopback data not routed");
  AST_DEAD_QUIET: assert property (@(posedge clk) disable iff (rst)
    $rose(loopEn) |=> !rxDv [*8])
    else $error("receive valid during dead time");

endmodule : pbm_loopback

/* logic/pbm_basic_ctrl.sv */
`timescale 1ns/1ps
module pbm_basic_ctrl #(
  parameter int DEAD_CYCLES = pbm_pkg::DEADTIME_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        mdc,
  input  wire logic        mdioIn,
  output logic             mdioOut,
  output logic             mdioOe,
  input  wire logic [4:0]  phyAddr,
  input  wire logic        strapSpeed100,
  input  wire logic        strapAutoNeg,
  input  wire logic        strapFullDuplex,
  input  wire logic        anSpeed100,
  input  wire logic        anFullDuplex,
  input  wire logic        linkUp,
  input  wire logic        eventActive,
  input  wire logic        jabberEvent,
  input  wire logic        symbolError,
  input  wire logic [39:0] lqParamVals,
  input  wire logic [3:0]  txData,
  input  wire logic        txEn,
  input  wire logic [3:0]  lineRxData,
  input  wire logic        lineRxDv,
  output logic [3:0]       rxData,
  output logic             rxDv,
  output logic             speed100,
  output logic             fullDuplex,
  output logic             portInReset
);
  import pbm_pkg::*;

  logic        regRe;
  logic        regWe;
  logic [4:0]  regAddr;
  logic [15:0] wrData;
  logic [15:0] rdData;
  logic        wrBasic;
  logic        wrLqm;
  logic        wrLqd;
  logic        rdStatus;
  logic        rdLqm;

  logic        swRst;
  logic [7:0]  swCnt;
  logic        loadStraps;
  logic        loopEn;
  logic        speedSel;
  logic        anEn;
  logic        duplexSel;

  logic        evtBit;
  logic        linkLatch;
  logic        jabLatch;
  logic [7:0]  errCnt;

  logic        lqmEn;
  logic [9:0]  warn;
  logic [9:0]  warnHit;
  logic [7:0]  lqData;
  logic [2:0]  lqPsel;
  logic        lqTsel;
  logic [7:0]  thrMem [16];

  ////////////////////////////////////////////////////////////////////////////
  // management access

  pbm_mdio_slave uMdio (
    .clk     (clk),
    .rst     (rst),
    .mdc     (mdc),
    .mdioIn  (mdioIn),
    .phyAddr (phyAddr),
    .rdData  (rdData),
    .mdioOut (mdioOut),
    .mdioOe  (mdioOe),
    .regRe   (regRe),
    .regWe   (regWe),
    .regAddr (regAddr),
    .wrData  (wrData)
  );

  // writes during a port reset are dropped, the reset owns the register
  assign wrBasic  = regWe && (regAddr == REG_BASIC_CTRL) && !swRst;
  assign wrLqm    = regWe && (regAddr == REG_LQ_MON) && !swRst;
  assign wrLqd    = regWe && (regAddr == REG_LQ_DATA) && !swRst;
  assign rdStatus = regRe && (regAddr == REG_LINK_STATUS);
  assign rdLqm    = regRe && (regAddr == REG_LQ_MON);

  always_comb
  begin
    rdData = 16'h0000;
    if (regAddr == REG_BASIC_CTRL)
    begin
      rdData[BC_RESET]  = swRst;
      rdData[BC_LOOP]   = loopEn;
      rdData[BC_SPEED]  = speedSel;
      rdData[BC_ANEN]   = anEn;
      rdData[BC_DUPLEX] = duplexSel;
    end
    else if (regAddr == REG_LINK_STATUS)
    begin
      rdData[LS_FIXED]             = LS_FIXED_VAL;
      rdData[LS_EVENT]             = evtBit;
      rdData[LS_LINK]              = linkLatch;
      rdData[LS_JABBER]            = jabLatch;
      rdData[LS_ERR_LO +: 8]       = errCnt;
    end
    else if (regAddr == REG_LQ_MON)
    begin
      rdData[LQM_ENABLE]           = lqmEn;
      rdData[LQM_WARNS-1:0]        = warn;
    end
    else if (regAddr == REG_LQ_DATA)
    begin
      rdData[LQD_PSEL +: 3]        = lqPsel;
      rdData[LQD_TSEL]             = lqTsel;
      rdData[7:0]                  = lqData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software reset and strap reload

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      swRst <= 1'b0;
      swCnt <= 8'h00;
    end
    else if (wrBasic && wrData[BC_RESET])
    begin
      swRst <= 1'b1;
      swCnt <= 8'(SWRESET_CYCLES - 1);
    end
    else if (swRst)
    begin
      if (swCnt == 8'h00)
        swRst <= 1'b0;
      else
        swCnt <= swCnt - 8'h01;
    end
  end

  // straps are caught one edge after either reset ends
  always_ff @(posedge clk)
    loadStraps <= rst | (swRst & (swCnt == 8'h00));

  always_ff @(posedge clk)
  begin
    if (rst || swRst)
    begin
      loopEn    <= 1'b0;
      speedSel  <= 1'b0;
      anEn      <= 1'b0;
      duplexSel <= 1'b0;
    end
    else if (loadStraps)
    begin
      speedSel  <= strapSpeed100;
      anEn      <= strapAutoNeg;
      duplexSel <= strapFullDuplex;
    end
    else if (wrBasic)
    begin
      loopEn    <= wrData[BC_LOOP];
      speedSel  <= wrData[BC_SPEED];
      anEn      <= wrData[BC_ANEN];
      duplexSel <= wrData[BC_DUPLEX];
    end
  end

  always_ff @(posedge clk)
    portInReset <= rst | swRst | loadStraps;

  // negotiated result wins while negotiation is on
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      speed100   <= 1'b0;
      fullDuplex <= 1'b0;
    end
    else
    begin
      speed100   <= anEn ? anSpeed100 : speedSel;
      fullDuplex <= anEn ? anFullDuplex : duplexSel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link status bits, all read-only

  always_ff @(posedge clk)
    evtBit <= rst ? 1'b0 : eventActive;

  // events beat a simultaneous read so nothing is lost
  always_ff @(posedge clk)
  begin
    if (rst || swRst)
    begin
      linkLatch <= 1'b0;
      jabLatch  <= 1'b0;
      errCnt    <= 8'h00;
    end
    else
    begin
      if (!linkUp)
        linkLatch <= 1'b0;
      else if (rdStatus)
        linkLatch <= 1'b1;
      if (jabberEvent)
        jabLatch <= 1'b1;
      else if (rdStatus)
        jabLatch <= 1'b0;
      if (symbolError)
        errCnt <= rdStatus ? 8'h01 : (errCnt == 8'hFF ? errCnt : errCnt + 8'h01);
      else if (rdStatus)
        errCnt <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link quality monitor

  always_ff @(posedge clk)
  begin
    if (rst || swRst)
    begin
      lqmEn  <= 1'b0;
      lqData <= 8'h00;
      lqPsel <= 3'h0;
      lqTsel <= 1'b0;
    end
    else
    begin
      if (wrLqm)
        lqmEn <= wrData[LQM_ENABLE];
      if (wrLqd)
      begin
        lqPsel <= wrData[LQD_PSEL +: 3];
        lqTsel <= wrData[LQD_TSEL];
        // sample and write strobes finish in one cycle, so read as zero
        if (wrData[LQD_SAMPLE] && wrData[LQD_PSEL +: 3] < 3'(LQ_PARAMS))
          lqData <= lqParamVals[8 * wrData[LQD_PSEL +: 3] +: 8];
        else
          lqData <= wrData[7:0];
      end
    end
  end

  always_ff @(posedge clk)
    if (wrLqd && wrData[LQD_WRTHR])
      thrMem[wrData[LQD_TSEL +: 4]] <= wrData[7:0];

  // even entries are low limits, odd entries high limits
  genvar gp;
  generate
    for (gp = 0; gp < LQ_PARAMS; gp++)
    begin : gParam
      assign warnHit[2*gp]   = lqParamVals[8*gp +: 8] < thrMem[2*gp];
      assign warnHit[2*gp+1] = lqParamVals[8*gp +: 8] > thrMem[2*gp+1];
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (rst || swRst)
      warn <= 10'h000;
    else if (lqmEn)
      warn <= (rdLqm ? 10'h000 : warn) | warnHit;
    else if (rdLqm)
      warn <= 10'h000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // loopback path

  pbm_loopback #(
    .DEAD_CYCLES (DEAD_CYCLES)
  ) uLoop (
    .clk        (clk),
    .rst        (rst),
    .loopEn     (loopEn),
    .txData     (txData),
    .txEn       (txEn),
    .lineRxData (lineRxData),
    .lineRxDv   (lineRxDv),
    .rxData     (rxData),
    .rxDv       (rxDv)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence seqResetStart;
    wrBasic && wrData[BC_RESET];
  endsequence
  sequence seqResetRun;
    swRst [*8];
  endsequence

  AST_SWRST_RUN: assert property (seqResetStart |=> seqResetRun ##32 swRst ##1 !swRst)
    else $error("software reset length wrong");
  AST_STRAP_RELOAD: assert property ($fell(swRst) |-> loadStraps ##1
    (speedSel == $past(strapSpeed100)) && (anEn == $past(strapAutoNeg)))
    else $error("straps not reloaded");
  AST_SPEED_MANUAL: assert property (!anEn |=> speed100 == $past(speedSel))
    else $error("manual speed not applied");
  AST_AN_OVERRIDE: assert property (anEn |=>
    (speed100 == $past(anSpeed100)) && (fullDuplex == $past(anFullDuplex)))
    else $error("control bits not ignored");
  AST_EVENT_FOLLOW: assert property ($fell(eventActive) |=> !evtBit)
    else $error("event bit did not clear");
  AST_READ_CLEAR: assert property (rdStatus && !symbolError && !swRst |=> errCnt == 8'h00)
    else $error("count not cleared by read");
  AST_FIXED_BIT: assert property ((regAddr == REG_LINK_STATUS) |-> rdData[LS_FIXED])
    else $error("fixed bit changed");
  AST_LATCH_LOW_HOLD: assert property (!linkLatch && !rdStatus && !swRst |=> !linkLatch)
    else $error("latched low released early");
  AST_LATCH_HIGH_HOLD: assert property (jabLatch && !rdStatus && !swRst |=> jabLatch)
    else $error("latched high released early");
  AST_RSVD_ZERO: assert property (((regAddr == REG_BASIC_CTRL) |-> (rdData & ~BC_MASK) == 16'h0)
    and ((regAddr == REG_LQ_MON) |-> (rdData & ~LQM_MASK) == 16'h0))
    else $error("reserved bits not zero");

endmodule : pbm_basic_ctrl

/* sim/pbm_mgmt_host.sv */
`timescale 1ns/1ps
module pbm_mgmt_host #(
  parameter logic [4:0] PHY = 5'h01
) (
  input  wire logic clk,
  input  wire logic mdioOut,
  input  wire logic mdioOe,
  output logic      mdc,
  output logic      mdioIn
);
  import pbm_pkg::*;
  logic hostOe;
  logic hostVal;

  // line has a pull-up, so a released line reads one, never the last value
  assign mdioIn = mdioOe ? mdioOut : (hostOe ? hostVal : 1'b1);

  initial
  begin
    mdc = 1'b0;
    hostOe = 1'b0;
    hostVal = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one bit: sample before the rise, 2 clk high, 2 clk low
  task automatic slot(input logic drv, input logic val, output logic smp);
    smp = mdioIn;
    hostOe = drv;
    hostVal = val;
    mdc = 1'b1;
    repeat (2) @(posedge clk);
    #1 mdc = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : slot

  task automatic xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [13:0] hdr;
    logic        wrOp;
    logic        s;
    hdr = {2'b01, op, PHY, ra};
    wrOp = (op == OP_WRITE);
    for (int i = 0; i < 32; i++) slot(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) slot(1'b1, hdr[i], s);
    // turnaround: host lets go on reads so the device can take the line
    slot(wrOp, 1'b1, s);
    slot(wrOp, 1'b0, s);
    for (int i = 15; i >= 0; i--)
    begin
      slot(wrOp, wd[i], s);
      rd[i] = s;
    end
    hostOe = 1'b0;
  endtask : xfer
endmodule : pbm_mgmt_host

/* sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import pbm_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        mdc;
  logic        mdioIn;
  logic        mdioOut;
  logic        mdioOe;
  logic        sSpd = 1'b1;
  logic        sAn = 1'b0;
  logic        sDup = 1'b1;
  logic        anSpd = 1'b0;
  logic        anDup = 1'b0;
  logic        linkUp = 1'b1;
  logic        eventActive = 1'b0;
  logic        jabberEvent = 1'b0;
  logic        symbolError = 1'b0;
  logic [39:0] lqParamVals = 40'h0;
  logic [3:0]  txData = 4'h0;
  logic        txEn = 1'b0;
  logic [3:0]  lineRxData = 4'h0;
  logic        lineRxDv = 1'b0;
  logic [3:0]  rxData;
  logic        rxDv;
  logic        speed100;
  logic        fullDuplex;
  logic        portInReset;
  int          nMismatch = 0;
  int          numChecks = 0;
  logic [15:0] v;

  always #12.5 clk = ~clk;

  pbm_basic_ctrl #(.DEAD_CYCLES(50)) uut (
    .clk(clk), .rst(rst), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut),
    .mdioOe(mdioOe), .phyAddr(5'h01), .strapSpeed100(sSpd), .strapAutoNeg(sAn),
    .strapFullDuplex(sDup), .anSpeed100(anSpd), .anFullDuplex(anDup),
    .linkUp(linkUp), .eventActive(eventActive), .jabberEvent(jabberEvent),
    .symbolError(symbolError), .lqParamVals(lqParamVals), .txData(txData),
    .txEn(txEn), .lineRxData(lineRxData), .lineRxDv(lineRxDv), .rxData(rxData),
    .rxDv(rxDv), .speed100(speed100), .fullDuplex(fullDuplex),
    .portInReset(portInReset)
  );

  pbm_mgmt_host #(.PHY(5'h01)) mgmt (
    .clk(clk), .mdioOut(mdioOut), .mdioOe(mdioOe), .mdc(mdc), .mdioIn(mdioIn)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    mgmt.xfer(OP_READ, a, 16'h0000, d);
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] junk;
    mgmt.xfer(OP_WRITE, a, d, junk);
    tick(2);
  endtask : wr

  task automatic conclude();
    if (nMismatch == 0 && numChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////////
  task automatic run_reset_values();
    check("speed100", speed100, 16'h0001);
    check("fullDuplex", fullDuplex, 16'h0001);
    rd(REG_BASIC_CTRL, v);
    check("ctrl after reset", v, 16'h2100);
    wr(REG_LINK_STATUS, 16'h0000);
    rd(REG_LINK_STATUS, v);
    check("fixed status bit", v[LS_FIXED], LS_FIXED_VAL);
  endtask : run_reset_values

  task automatic run_speed_select();
    wr(REG_BASIC_CTRL, 16'h2EFF);
    rd(REG_BASIC_CTRL, v);
    check("ctrl reserved", v, 16'h2000);
    check("speed100 forced", speed100, 16'h0001);
    wr(REG_BASIC_CTRL, 16'h0100);
    check("speed100 off", speed100, 16'h0000);
    anSpd = 1'b1;
    wr(REG_BASIC_CTRL, 16'h1100);
    // negotiated result wins while autoneg enabled
    check("speed100 an", speed100, 16'h0001);
    check("duplex an", fullDuplex, 16'h0000);
  endtask : run_speed_select

  task automatic run_loopback();
    lineRxData = 4'h5;
    lineRxDv = 1'b1;
    txData = 4'hA;
    txEn = 1'b1;
    tick(3);
    check("rx normal", {rxDv, rxData}, 16'h0015);
    wr(REG_BASIC_CTRL, 16'h4000);
    tick(20);
    check("rx dead", {rxDv, rxData}, 16'h0000);
    tick(60);
    check("rx looped", {rxDv, rxData}, 16'h001A);
    txData = 4'h3;
    tick(2);
    check("rx follows tx", {rxDv, rxData}, 16'h0013);
    wr(REG_BASIC_CTRL, 16'h0000);
    tick(3);
    check("rx restored", {rxDv, rxData}, 16'h0015);
  endtask : run_loopback

  task automatic run_soft_reset();
    wr(REG_BASIC_CTRL, 16'h4100);
    sSpd = 1'b0;
    sAn = 1'b1;
    sDup = 1'b0;
    wr(REG_BASIC_CTRL, 16'hC100);
    check("reset running", portInReset, 16'h0001);
    tick(28);
    check("reset still running", portInReset, 16'h0001);
    for (int i = 0; i < 100 && portInReset !== 1'b0; i++) tick(1);
    check("reset done", portInReset, 16'h0000);
    tick(2);
    rd(REG_BASIC_CTRL, v);
    // straps reloaded, loopback gone, reset bit cleared
    check("ctrl restrapped", v, 16'h1000);
    check("speed100 an", speed100, 16'h0001);
  endtask : run_soft_reset

  task automatic run_status();
    rd(REG_LINK_STATUS, v);
    linkUp = 1'b0;
    tick(3);
    linkUp = 1'b1;
    jabberEvent = 1'b1;
    tick(1);
    jabberEvent = 1'b0;
    repeat (3)
    begin
      symbolError = 1'b1;
      tick(1);
      symbolError = 1'b0;
      tick(1);
    end
    eventActive = 1'b1;
    tick(2);
    rd(REG_LINK_STATUS, v);
    check("status latched", v, 16'h030B);
    eventActive = 1'b0;
    wr(REG_LINK_STATUS, 16'hFFFF);
    rd(REG_LINK_STATUS, v);
    check("status after read", v, 16'h0005);
  endtask : run_status

  task automatic run_link_quality();
    logic [7:0] thr;
    for (int p = 0; p < LQ_PARAMS; p++)
      for (int t = 0; t < 2; t++)
      begin
        thr = (t == 0) ? 8'h00 : 8'hFF;
        if (p == 0) thr = (t == 0) ? 8'h10 : 8'h80;
        wr(REG_LQ_DATA, {3'h0, 1'b1, 3'(p), 1'(t), thr});
      end
    lqParamVals[7:0] = 8'h05;
    wr(REG_LQ_MON, 16'hFFFF);
    tick(4);
    lqParamVals[7:0] = 8'h40;
    tick(2);
    rd(REG_LQ_MON, v);
    check("warn held", v, 16'h8001);
    rd(REG_LQ_MON, v);
    check("warn cleared", v, 16'h8000);
    wr(REG_LQ_DATA, 16'h2000);
    rd(REG_LQ_DATA, v);
    check("sampled param", v, 16'h0040);
  endtask : run_link_quality

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    tick(3);
    run_reset_values();
    run_speed_select();
    run_loopback();
    run_soft_reset();
    run_status();
    run_link_quality();
    conclude();
  end

  // about 8100 clk expected; generous margin before declaring a hang
  initial
  begin
    repeat (30000) @(posedge clk);
    nMismatch++;
    conclude();
  end
endmodule : testbench
